// >>> tb_watchdog_timer_clear_sleep.sv
// Self-checking testbench of the watchdog core
`timescale 1ns/100ps
module tb_watchdog_timer_clear_sleep
  import wdt_pkg::*;
;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  typedef struct {logic [1:0] mode; logic [5:0] ctrl; int ticks; int resets;} row_t;
  logic clk_i, rst_i, cyc, stb, we, ack, osc, xtal, clr, sleep, fail, oscillator_startup_timer, wdt_rst, wake, to_n, pd_n, irq;
  logic [1:0] mode;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  int errors = 0;
  int samples_checked = 0;
  int rst_cnt = 0;
  int wake_cnt = 0;
  int cycles = 0;
  int r0, w0;
  row_t rows[8] = '{
    '{2'b11, 6'h00, 32, 1}, '{2'b11, 6'h02, 64, 1}, '{2'b11, 6'h26, 32, 1}, '{2'b11, 6'h3E, 32, 1},
    '{2'b01, 6'h01, 32, 1}, '{2'b01, 6'h00, 32, 0}, '{2'b00, 6'h01, 32, 0}, '{2'b10, 6'h00, 32, 1}};

  wdt_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .low_freq_internal_osc_i(osc),
    .config_mode_bits_i(mode), .crystal_clock_i(xtal), .clear_instruction_i(clr), .sleep_i(sleep),
    .osc_fail_i(fail), .oscillator_startup_timer_i(oscillator_startup_timer), .wdt_reset_o(wdt_rst), .wake_o(wake),
    .timeout_status_flag_n_o(to_n), .powerdown_status_flag_n_o(pd_n), .irq_o(irq));

  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Pulse tallies and hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (wdt_rst === 1'b1) rst_cnt++;
    if (wake === 1'b1) wake_cnt++;
    if (cycles == 40000)
    begin
      errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    // A bus answer that never comes counts as a mismatch
    if (ack !== 1'b1)
    begin
      errors++;
      $display("CHECK FAILED bus ack expected 1 seen %b", ack);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // One oscillator period, eight clocks long
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i) osc <= 1'b1;
      repeat (4) @(posedge clk_i);
      osc <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  task automatic pulse_clear;
    @(posedge clk_i) clr <= 1'b1;
    @(posedge clk_i) clr <= 1'b0;
  endtask

  // Run n ticks and compare reset and wake pulses against expectation
  task automatic run(input int n, input int er, input int ew, input string name);
    r0 = rst_cnt;
    w0 = wake_cnt;
    ticks(n);
    repeat (8) @(posedge clk_i);
    check({name, " resets"}, rst_cnt - r0, er);
    check({name, " wakes"}, wake_cnt - w0, ew);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {cyc, stb, we, osc, xtal, clr, sleep, fail, oscillator_startup_timer} = '0;
    rst_i = 1'b1;
    mode = 2'b00;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values
    wb(1'b0, 8'h00, 32'h0, rd);
    check("control reset", rd, 32'h16);
    wb(1'b0, 8'h04, 32'h0, rd);
    check("status reset", rd, 32'h18);
    check("irq reset", irq, 1'b0);
    $display("reset test done");
    // Period codes and modes from the table
    foreach (rows[i])
    begin
      @(posedge clk_i) mode <= rows[i].mode;
      wb(1'b1, 8'h00, {26'h0, rows[i].ctrl}, rd);
      pulse_clear();
      run(rows[i].ticks - 1, 0, 0, "row early");
      run(1, rows[i].resets, 0, "row expiry");
      if (rows[i].resets == 1)
        check("row timeout flag", to_n, 1'b0);
      wb(1'b0, 8'h10, 32'h0, rd);
      check("row count restart", rd, 32'h0);
      $display("row %0d done", i);
    end
    // Clear instruction in mid-count, fail and start-up holds
    @(posedge clk_i) mode <= 2'b11;
    pulse_clear();
    run(20, 0, 0, "before clear");
    pulse_clear();
    // Flags land at the edge that samples the clear, so look one edge later
    @(posedge clk_i);
    check("flags after clear", {to_n, pd_n}, 2'b11);
    run(20, 0, 0, "after clear");
    run(12, 1, 0, "full period");
    @(posedge clk_i) fail <= 1'b1;
    run(40, 0, 0, "osc fail");
    @(posedge clk_i) fail <= 1'b0;
    xtal <= 1'b1;
    oscillator_startup_timer <= 1'b1;
    run(40, 0, 0, "crystal startup");
    @(posedge clk_i) xtal <= 1'b0;
    pulse_clear();
    run(32, 1, 0, "other clock");
    $display("clear test done");
    // Sleep time-out wakes, sets flags and the interrupt
    @(posedge clk_i) oscillator_startup_timer <= 1'b0;
    wb(1'b1, 8'h0C, 32'h3, rd);
    wb(1'b1, 8'h08, 32'h3, rd);
    @(posedge clk_i) sleep <= 1'b1;
    run(31, 0, 0, "sleep early");
    check("flags in sleep", {to_n, pd_n}, 2'b10);
    run(1, 0, 1, "sleep expiry");
    check("flags after wake", {to_n, pd_n}, 2'b00);
    check("irq wake", irq, 1'b1);
    wb(1'b0, 8'h04, 32'h0, rd);
    check("wake sticky", rd[1], 1'b1);
    wb(1'b1, 8'h08, 32'h1, rd);
    repeat (2) @(posedge clk_i);
    check("irq masked", irq, 1'b0);
    wb(1'b1, 8'h08, 32'h2, rd);
    repeat (2) @(posedge clk_i);
    check("irq unmasked", irq, 1'b1);
    wb(1'b1, 8'h0C, 32'h2, rd);
    repeat (2) @(posedge clk_i);
    check("irq cleared", irq, 1'b0);
    // Mode that stops in sleep
    @(posedge clk_i) mode <= 2'b10;
    run(40, 0, 0, "mode off in sleep");
    @(posedge clk_i) sleep <= 1'b0;
    $display("sleep test done");
    // Unmapped and write-only reads
    wb(1'b0, 8'h20, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    wb(1'b0, 8'h0C, 32'h0, rd);
    check("clear register read", rd, 32'h0);
    $display("bus test done");
    conclude();
  end
endmodule

// >>> wdt_consts.svh
// Register offsets, field positions, reset values and ratios of the watchdog
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WDT_OFS_CONTROL 8'h00
`define WDT_OFS_STATUS 8'h04
`define WDT_OFS_IRQ_ENABLE 8'h08
`define WDT_OFS_IRQ_CLEAR 8'h0C
`define WDT_OFS_COUNT 8'h10

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_PS_LSB 1
`define WDT_CTRL_PS_MSB 5
`define WDT_PS_RESET 5'h0B
`define WDT_EN_RESET 1'b0

// ----------------------------------------
// Status and interrupt fields
// ----------------------------------------
`define WDT_IRQ_AWAKE 0
`define WDT_IRQ_WAKE 1
`define WDT_ST_ACTIVE 2
`define WDT_ST_TO_N 3
`define WDT_ST_PD_N 4

// ----------------------------------------
// Prescale ratios
// ----------------------------------------
`define WDT_PS_MAX 5'h12
`define WDT_BASE_RATIO 24'h000020

`endif

// >>> wdt_core.sv
// Watchdog timer with sleep handling and a classic Wishbone register slave
`timescale 1ns/100ps
`include "wdt_consts.svh"

// Overview of operation
// [RQ1] The count clears on reset, clear instruction, sleep entry and exit, oscillator failure, disable, start-up timer with a crystal clock.
// [RQ2] After the clear at sleep entry the count runs on in sleep when the mode keeps it enabled.
// [RQ3] On leaving sleep the count clears and, with a crystal clock, stays clear while the start-up timer runs.
// [RQ4] A time-out during sleep wakes the device and gives no reset.
// [RQ5] A sleep time-out wake drives both the time-out and power-down flags low.
// [RQ6] With a crystal clock the count stays clear until the start-up timer ends, otherwise it clears once.
// [RQ7] A change of the internal oscillator divider leaves the count untouched.
// [RQ8] Period select in bits 5..1 gives ratio 32 doubled per code up to code 18.
// [RQ9] Period select resets to code 11, ratio 65536.
// [RQ10] Codes 19 to 31 act as the minimum ratio 32.
// [RQ11] Software enable in bit 0 matters only in mode 01.
// [RQ12] The time base is only the slow internal oscillator.
// [RQ13] Mode 11 always on, 10 on except in sleep, 01 software, 00 off.
// [RQ14] Firmware must clear in time, else an awake time-out resets the device.
// [RQ15] A time-out is detected when the count reaches the ratio and the count restarts at zero.
module wdt_core
  import wdt_pkg::*;
#(
  parameter int CNT_W = 24
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Time base and configuration
  input wire logic low_freq_internal_osc_i,
  input wire logic [1:0] config_mode_bits_i,
  input wire logic crystal_clock_i,
  // CPU events
  input wire logic clear_instruction_i,
  input wire logic sleep_i,
  input wire logic osc_fail_i,
  input wire logic oscillator_startup_timer_i,
  // Results
  output logic wdt_reset_o,
  output logic wake_o,
  output logic timeout_status_flag_n_o,
  output logic powerdown_status_flag_n_o,
  output logic irq_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cfg_mode_t mode;
  logic [4:0] period_reg, period_next;
  logic swen_reg, swen_next;
  logic [1:0] ien_reg, ien_next;
  logic [1:0] ist_reg, ist_next;
  logic irq_reg, irq_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic sleep_reg;
  logic to_n_reg, to_n_next, pd_n_reg, pd_n_next;
  logic rst_out_reg, rst_out_next, wake_reg, wake_next;
  logic active, sleep_entry, sleep_exit, cnt_clear, tick, tmo;
  logic wr_en, rd_en;
  logic [CNT_W-1:0] ratio, count;

  // ----------------------------------------
  // Time base and counter
  // ----------------------------------------

  // Slow oscillator pin, the only time base
  wdt_sync3 u_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(low_freq_internal_osc_i), // RQ12
    .rise_o(tick)
  );

  // Mode decode and clearing conditions
  always_comb
  begin
    mode = cfg_mode_t'(config_mode_bits_i);
    unique case (mode)
      MODE_ON: active = 1'b1; // RQ2 RQ13
      MODE_NO_SLEEP: active = ~sleep_i; // RQ13
      MODE_SOFT: active = swen_reg; // RQ11
      MODE_OFF: active = 1'b0; // RQ13
    endcase
    sleep_entry = sleep_i & ~sleep_reg;
    sleep_exit = ~sleep_i & sleep_reg;
    // Start-up timer input runs only for crystal clocks, awake or after wake
    // Non-crystal clocks see only the single clear at the sleep edge
    // Any clear term blocks the time-out in the same cycle
    cnt_clear = clear_instruction_i | sleep_entry | sleep_exit | osc_fail_i | ~active // RQ1
      | (oscillator_startup_timer_i & crystal_clock_i); // RQ3 RQ6
    ratio = CNT_W'(period_ratio(period_reg)); // RQ8 RQ10
  end

  // Ratio counter; no divider select reaches it
  wdt_prescaler #(.CNT_W(CNT_W)) u_presc
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(cnt_clear), // RQ7
    .tick_i(tick),
    .ratio_i(ratio),
    .timeout_o(tmo), // RQ15
    .count_o(count)
  );

  // ----------------------------------------
  // Time-out actions and status flags
  // ----------------------------------------

  // Awake time-out resets, sleep time-out wakes
  always_comb
  begin
    rst_out_next = tmo & ~sleep_i; // RQ14
    wake_next = tmo & sleep_i; // RQ4
    to_n_next = to_n_reg;
    pd_n_next = pd_n_reg;
    if (clear_instruction_i)
    begin
      to_n_next = 1'b1;
      pd_n_next = 1'b1;
    end
    if (sleep_entry)
    begin
      to_n_next = 1'b1;
      pd_n_next = 1'b0;
    end
    if (tmo)
    begin
      to_n_next = 1'b0; // RQ5
      pd_n_next = ~sleep_i; // RQ5
    end
  end

  // Event and flag registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sleep_reg <= 1'b0;
      rst_out_reg <= 1'b0;
      wake_reg <= 1'b0;
      to_n_reg <= 1'b1;
      pd_n_reg <= 1'b1;
    end
    else
    begin
      sleep_reg <= sleep_i;
      rst_out_reg <= rst_out_next;
      wake_reg <= wake_next;
      to_n_reg <= to_n_next;
      pd_n_reg <= pd_n_next;
    end
  end

  // ----------------------------------------
  // Register slave and interrupts
  // ----------------------------------------

  // Decode, write at the acknowledged edge, registered read data
  // Ack answers one cycle after the request and lasts one cycle
  // Read data stands only while ack is high, zero otherwise
  always_comb
  begin
    rd_en = wb_cyc_i & wb_stb_i & ~ack_reg;
    wr_en = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
    ack_next = rd_en;
    period_next = period_reg;
    swen_next = swen_reg;
    ien_next = ien_reg;
    ist_next = ist_reg;
    if (wr_en && wb_adr_i == `WDT_OFS_CONTROL)
    begin
      period_next = wb_dat_i[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB]; // RQ8
      swen_next = wb_dat_i[`WDT_CTRL_EN_BIT]; // RQ11
    end
    if (wr_en && wb_adr_i == `WDT_OFS_IRQ_ENABLE)
      ien_next = wb_dat_i[1:0];
    if (wr_en && wb_adr_i == `WDT_OFS_IRQ_CLEAR)
      ist_next = ist_reg & ~wb_dat_i[1:0];
    // Set wins over a clear in the same cycle
    ist_next[`WDT_IRQ_AWAKE] = ist_next[`WDT_IRQ_AWAKE] | rst_out_next;
    ist_next[`WDT_IRQ_WAKE] = ist_next[`WDT_IRQ_WAKE] | wake_next;
    irq_next = |(ist_next & ien_next);
    dat_next = 32'h00000000;
    if (rd_en && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `WDT_OFS_CONTROL: dat_next = {26'h0, period_reg, swen_reg};
        `WDT_OFS_STATUS: dat_next = {27'h0, pd_n_reg, to_n_reg, active, ist_reg};
        `WDT_OFS_IRQ_ENABLE: dat_next = {30'h0, ien_reg};
        `WDT_OFS_COUNT: dat_next = 32'(count);
        default: dat_next = 32'h00000000;
      endcase
    end
  end

  // Register file
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      period_reg <= `WDT_PS_RESET; // RQ9
      swen_reg <= `WDT_EN_RESET;
      ien_reg <= 2'h0;
      ist_reg <= 2'h0;
      irq_reg <= 1'b0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      period_reg <= period_next;
      swen_reg <= swen_next;
      ien_reg <= ien_next;
      ist_reg <= ist_next;
      irq_reg <= irq_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // Outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;
  assign wdt_reset_o = rst_out_reg;
  assign wake_o = wake_reg;
  assign timeout_status_flag_n_o = to_n_reg;
  assign powerdown_status_flag_n_o = pd_n_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_clear_instruction_clears: assert property (clear_instruction_i |=> count == '0) // RQ1
    else $error("count not cleared by clear instruction");
  a_disabled_held: assert property (config_mode_bits_i == 2'b00 [*2] |-> count == '0) // RQ13
    else $error("count moves while mode is off");
  a_sleep_entry_clr: assert property ($rose(sleep_i) |=> count == '0) // RQ2
    else $error("count not cleared at sleep entry");
  a_sleep_exit_clr: assert property ($fell(sleep_i) |=> count == '0) // RQ3
    else $error("count not cleared at sleep exit");
  a_ost_hold: assert property (oscillator_startup_timer_i && crystal_clock_i |=> count == '0) // RQ6
    else $error("count moves during start-up timer");
  a_sleep_wake: assert property (tmo && sleep_i |=> wake_o && !wdt_reset_o) // RQ4
    else $error("sleep time-out did not wake");
  a_wake_flags: assert property (wake_o |-> !timeout_status_flag_n_o && !powerdown_status_flag_n_o) // RQ5
    else $error("flags wrong after sleep wake");
  a_awake_reset: assert property (tmo && !sleep_i |=> wdt_reset_o && !wake_o) // RQ14
    else $error("awake time-out gave no reset");
  a_reserved_min: assert property (period_reg > 5'h12 |-> ratio == CNT_W'(32)) // RQ10
    else $error("reserved code not minimum ratio");
  a_period_reset: assert property ($past(rst_i) |-> period_reg == 5'h0B) // RQ9
    else $error("period select reset value wrong");
  a_soft_ignored: assert property (config_mode_bits_i == 2'b11 && !swen_reg |-> active) // RQ11
    else $error("software enable not ignored");
  a_tmo_restart: assert property (tmo |=> count == '0) // RQ15
    else $error("count not restarted after time-out");


  // Status, flags and bus answer shape
  a_awake_sticky: assert property (wdt_reset_o |-> ist_reg[`WDT_IRQ_AWAKE]) // RQ14
    else $error("awake time-out not recorded");
  a_wake_sticky: assert property (wake_o |-> ist_reg[`WDT_IRQ_WAKE]) // RQ5
    else $error("sleep wake not recorded");
  a_awake_flags: assert property (wdt_reset_o |-> !timeout_status_flag_n_o && powerdown_status_flag_n_o) // RQ14
    else $error("flags wrong after awake time-out");
  a_entry_flags: assert property ($rose(sleep_i) |=> timeout_status_flag_n_o && !powerdown_status_flag_n_o) // RQ5
    else $error("flags wrong after sleep entry");
  a_nosleep_off: assert property (config_mode_bits_i == 2'b10 && sleep_i |=> count == '0) // RQ13
    else $error("count moves in sleep while mode stops it");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside an answer");

  c_sleep_count: cover property (sleep_i && count != '0);
  c_sleep_wake: cover property (wake_o);
  c_awake_reset: cover property (wdt_reset_o);
  c_clear_running: cover property (count != '0 ##1 clear_instruction_i);
  c_irq: cover property (irq_o);
endmodule

// >>> wdt_pkg.sv
// Types and shared functions of the watchdog
package wdt_pkg;
  `include "wdt_consts.svh"

  // Configuration mode bits
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOFT = 2'b01,
    MODE_NO_SLEEP = 2'b10,
    MODE_ON = 2'b11
  } cfg_mode_t;

  // Ratio of oscillator ticks per time-out; reserved codes give the minimum
  function automatic logic [23:0] period_ratio(input logic [4:0] code);
    if (code > `WDT_PS_MAX)
      period_ratio = `WDT_BASE_RATIO;
    else
      period_ratio = `WDT_BASE_RATIO << code;
  endfunction
endpackage

// >>> wdt_prescaler.sv
// Tick counter that flags a time-out at the selected ratio
`timescale 1ns/100ps
module wdt_prescaler
#(
  parameter int CNT_W = 24
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [CNT_W-1:0] ratio_i,
  // Result
  output logic timeout_o,
  output logic [CNT_W-1:0] count_o
);
  logic [CNT_W-1:0] count_reg, count_next;
  logic hit;

  // Clear wins; on reaching the ratio restart from zero
  always_comb
  begin
    hit = tick_i & ~clear_i & (count_reg >= ratio_i - 1'b1);
    count_next = count_reg;
    if (clear_i || hit)
      count_next = '0;
    else if (tick_i)
      count_next = count_reg + 1'b1;
  end

  // Count register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign timeout_o = hit;
  assign count_o = count_reg;
endmodule

// >>> wdt_sync3.sv
// Three-stage synchroniser with edge detect for the slow oscillator pin
`timescale 1ns/100ps
module wdt_sync3
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous pin
  input wire logic pin_i,
  // Filtered rising edge
  output logic rise_o
);
  logic s1_reg, s2_reg, s3_reg, level_reg, rise_reg;
  logic level_next, rise_next;

  // Level changes only once stages two and three agree
  always_comb
  begin
    level_next = level_reg;
    if (s2_reg == s3_reg)
      level_next = s3_reg;
    rise_next = level_next & ~level_reg;
  end

  // Register stages
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
      rise_reg <= rise_next;
    end
  end

  assign rise_o = rise_reg;
endmodule
